/* rtl/rmon_pkg.sv */
// shared constants of the resource monitor register bank
`default_nettype none

package rmon_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;

    // register indices; byte address is four times the index
    localparam logic [11:0] EVTSEL_IDX = 12'hc8d;
    localparam logic [11:0] CTR_IDX = 12'hc8e;
    localparam logic [11:0] ASSOC_IDX = 12'hc8f;
    localparam logic [15:0] EVTSEL_ADDR = {2'b00, EVTSEL_IDX, 2'b00};
    localparam logic [15:0] CTR_ADDR = {2'b00, CTR_IDX, 2'b00};
    localparam logic [15:0] ASSOC_ADDR = {2'b00, ASSOC_IDX, 2'b00};

    // upper 32 bits of each 64-bit register sit in a second window
    localparam int unsigned HI_WIN_BIT = 14;
    localparam logic [15:0] HI_WIN = 16'h4000;

    // interrupt and capability registers
    localparam logic [15:0] IRQ_STAT_ADDR = 16'h0000;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'h0004;
    localparam logic [15:0] CAPS_ADDR = 16'h0008;

    // fields
    localparam int unsigned EVT_CODE_W = 8;
    localparam int unsigned TAG_W = 10;
    localparam int unsigned EVT_TAG_LSB = 32;
    localparam int unsigned CTR_DATA_W = 62;
    localparam int unsigned CTR_UNAVAIL_BIT = 62;
    localparam int unsigned CTR_ERR_BIT = 63;
    localparam int unsigned CAP_QOS_BIT = 12;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_ERR_BIT = 0;
    localparam int unsigned IRQ_UNAV_BIT = 1;

    // reset values
    localparam logic [7:0] EVT_CODE_RST = 8'h00;
    localparam logic [9:0] TAG_RST = 10'h000;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* rtl/rmon_acc_if.sv */
// single-cycle register access between bus front and register bank
`default_nettype none

interface rmon_acc_if;
    logic wr;
    logic [rmon_pkg::ADDR_W-1:0] waddr;
    logic [rmon_pkg::DATA_W-1:0] wdata;
    logic [rmon_pkg::STRB_W-1:0] wstrb;
    logic wr_err;
    logic rd;
    logic [rmon_pkg::ADDR_W-1:0] raddr;
    logic [rmon_pkg::DATA_W-1:0] rdata;
    logic rd_err;

    modport front (
        output wr, waddr, wdata, wstrb, rd, raddr,
        input wr_err, rdata, rd_err
    );
    modport regs (
        input wr, waddr, wdata, wstrb, rd, raddr,
        output wr_err, rdata, rd_err
    );
endinterface

`default_nettype wire

/* rtl/rmon_axil_front.sv */
// axi4-lite slave front turning bus transfers into one-cycle accesses
`default_nettype none

module rmon_axil_front (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write address and data
    input wire logic [rmon_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rmon_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [rmon_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read
    input wire logic [rmon_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rmon_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    rmon_acc_if.front acc
);

    typedef struct packed {
        logic aw_full;
        logic [rmon_pkg::ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [rmon_pkg::DATA_W-1:0] w_data;
        logic [rmon_pkg::STRB_W-1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [rmon_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } rmon_front_s;

    rmon_front_s q;
    rmon_front_s d;

    assign s_axi_awready = !q.aw_full;
    assign s_axi_wready = !q.w_full;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // a write goes out once address and data are both held and b is free
    assign acc.wr = q.aw_full && q.w_full && !q.bvalid;
    assign acc.waddr = q.aw_addr;
    assign acc.wdata = q.w_data;
    assign acc.wstrb = q.w_strb;
    assign acc.rd = s_axi_arvalid && !q.rvalid;
    assign acc.raddr = s_axi_araddr;

    always_comb begin
        d = q;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && !q.aw_full) begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_full) begin
            d.w_full = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (acc.wr) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = acc.wr_err ? rmon_pkg::RESP_SLVERR : rmon_pkg::RESP_OKAY;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (acc.rd) begin
            d.rvalid = 1'b1;
            d.rdata = acc.rdata;
            d.rresp = acc.rd_err ? rmon_pkg::RESP_SLVERR : rmon_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* rtl/rmon_sel_check.sv */
// validates a new selection and keeps the error flag of the last one
`default_nettype none

module rmon_sel_check #(
    parameter int unsigned NUM_TAGS = 64,
    parameter logic [255:0] EVT_MASK = 256'h000e
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // selection being written
    input wire logic sel_wr,
    input wire logic [rmon_pkg::TAG_W-1:0] new_tag,
    input wire logic [rmon_pkg::EVT_CODE_W-1:0] new_code,
    // result
    output logic sel_err,
    output logic err_evt
);

    typedef struct packed {
        logic err;
    } rmon_chk_s;

    rmon_chk_s q;
    rmon_chk_s d;
    logic bad;

    assign bad = (32'(new_tag) >= NUM_TAGS) || !EVT_MASK[new_code];
    assign err_evt = sel_wr && bad;
    assign sel_err = q.err;

    always_comb begin
        d = q;
        if (sel_wr) begin
            d.err = bad; // see R4
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* rtl/rmon_regs.sv */
// resource monitor register bank behind an axi4-lite slave
//
// How it works
// R1: event select holds event code and tag.
// R2: counter low 62 bits give monitored data.
// R3: unavailable flag when data absent or unmonitored.
// R4: error flag after unsupported tag or code.
// R5: association register holds thread's monitoring tag.
// R6: registers exist only with capability bit set.
// R7: counter follows current selection; reserved read zero.
//
// The implementer's own choice: the AXI4-Lite register port.
`default_nettype none

module rmon_regs #(
    parameter logic QOS_SUPPORTED = 1'b1,
    parameter int unsigned NUM_TAGS = 64,
    parameter logic [255:0] EVT_MASK = 256'h000e
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // axi4-lite write address and data
    input wire logic [rmon_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rmon_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [rmon_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [rmon_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rmon_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // monitoring engine
    output logic [rmon_pkg::TAG_W-1:0] mon_tag,
    output logic [rmon_pkg::EVT_CODE_W-1:0] mon_code,
    input wire logic [rmon_pkg::CTR_DATA_W-1:0] mon_data,
    input wire logic mon_avail,
    // thread association
    output logic [rmon_pkg::TAG_W-1:0] assoc_tag,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic [rmon_pkg::EVT_CODE_W-1:0] evt_code;
        logic [rmon_pkg::TAG_W-1:0] evt_tag;
        logic [rmon_pkg::TAG_W-1:0] assoc_tag;
        logic [63:0] ctr_snap;
        logic [rmon_pkg::IRQ_W-1:0] irq_stat;
        logic [rmon_pkg::IRQ_W-1:0] irq_mask;
    } rmon_regs_s;

    rmon_regs_s q;
    rmon_regs_s d;

    rmon_acc_if acc ();

    // byte-lane merge of a write into a 32-bit view
    function automatic logic [31:0] merge32(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    rmon_axil_front u_front (
        .clk(ref_clk),
        .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .acc(acc)
    );

    // write decode; monitor registers vanish without the capability
    logic qos_on;
    logic wr_evt_lo;
    logic wr_evt_hi;
    logic wr_ctr;
    logic wr_assoc_lo;
    logic wr_assoc_hi;
    logic wr_stat;
    logic wr_mask;
    logic wr_caps;

    assign qos_on = QOS_SUPPORTED; // see R6
    assign wr_evt_lo = acc.wr && qos_on && acc.waddr == rmon_pkg::EVTSEL_ADDR;
    assign wr_evt_hi = acc.wr && qos_on
        && acc.waddr == (rmon_pkg::EVTSEL_ADDR | rmon_pkg::HI_WIN);
    assign wr_ctr = acc.wr && qos_on
        && (acc.waddr & ~rmon_pkg::HI_WIN) == rmon_pkg::CTR_ADDR;
    assign wr_assoc_lo = acc.wr && qos_on && acc.waddr == rmon_pkg::ASSOC_ADDR;
    assign wr_assoc_hi = acc.wr && qos_on
        && acc.waddr == (rmon_pkg::ASSOC_ADDR | rmon_pkg::HI_WIN);
    assign wr_stat = acc.wr && acc.waddr == rmon_pkg::IRQ_STAT_ADDR;
    assign wr_mask = acc.wr && acc.waddr == rmon_pkg::IRQ_MASK_ADDR;
    assign wr_caps = acc.wr && acc.waddr == rmon_pkg::CAPS_ADDR;

    // the counter is read-only; unmapped addresses answer slverr
    assign acc.wr_err = acc.wr && (wr_ctr || wr_caps
        || !(wr_evt_lo || wr_evt_hi || wr_assoc_lo || wr_assoc_hi || wr_stat || wr_mask));

    // proposed selection after this write
    logic [31:0] evt_lo_new;
    logic [31:0] evt_hi_new;
    logic [31:0] assoc_new;
    logic [31:0] w1c_word;
    logic [rmon_pkg::EVT_CODE_W-1:0] new_code;
    logic [rmon_pkg::TAG_W-1:0] new_tag;
    logic sel_wr;
    logic sel_err;
    logic err_evt;

    assign evt_lo_new = merge32({24'h0000_00, q.evt_code}, acc.wdata, acc.wstrb);
    assign evt_hi_new = merge32({22'h00_0000, q.evt_tag}, acc.wdata, acc.wstrb);
    assign assoc_new = merge32({22'h00_0000, q.assoc_tag}, acc.wdata, acc.wstrb);
    assign w1c_word = merge32(32'h0000_0000, acc.wdata, acc.wstrb);
    assign new_code = wr_evt_lo ? evt_lo_new[rmon_pkg::EVT_CODE_W-1:0] : q.evt_code;
    assign new_tag = wr_evt_hi ? evt_hi_new[rmon_pkg::TAG_W-1:0] : q.evt_tag;
    assign sel_wr = wr_evt_lo || wr_evt_hi;

    rmon_sel_check #(
        .NUM_TAGS(NUM_TAGS),
        .EVT_MASK(EVT_MASK)
    ) u_chk (
        .clk(ref_clk),
        .resetn(resetn),
        .sel_wr(sel_wr),
        .new_tag(new_tag),
        .new_code(new_code),
        .sel_err(sel_err),
        .err_evt(err_evt)
    );

    // live counter view for the current selection
    logic unavail;
    logic [63:0] ctr_live;

    assign unavail = !mon_avail || sel_err; // see R3
    assign ctr_live = {sel_err, unavail, mon_data}; // see R2

    // read decode
    logic rd_ctr_lo;
    logic unav_evt;

    assign rd_ctr_lo = acc.rd && qos_on && acc.raddr == rmon_pkg::CTR_ADDR;
    assign unav_evt = rd_ctr_lo && unavail;

    always_comb begin
        acc.rdata = 32'h0000_0000;
        acc.rd_err = 1'b0;
        case (acc.raddr)
            rmon_pkg::EVTSEL_ADDR: begin
                acc.rdata = {24'h0000_00, q.evt_code}; // see R7
                acc.rd_err = !qos_on;
            end
            rmon_pkg::EVTSEL_ADDR | rmon_pkg::HI_WIN: begin
                acc.rdata = {22'h00_0000, q.evt_tag};
                acc.rd_err = !qos_on;
            end
            rmon_pkg::CTR_ADDR: begin
                acc.rdata = ctr_live[31:0];
                acc.rd_err = !qos_on;
            end
            rmon_pkg::CTR_ADDR | rmon_pkg::HI_WIN: begin
                // upper half comes from the snapshot of the last low read
                acc.rdata = q.ctr_snap[63:32];
                acc.rd_err = !qos_on;
            end
            rmon_pkg::ASSOC_ADDR: begin
                acc.rdata = {22'h00_0000, q.assoc_tag}; // see R5
                acc.rd_err = !qos_on;
            end
            rmon_pkg::ASSOC_ADDR | rmon_pkg::HI_WIN: begin
                acc.rdata = 32'h0000_0000;
                acc.rd_err = !qos_on;
            end
            rmon_pkg::IRQ_STAT_ADDR: begin
                acc.rdata = {30'h0000_0000, q.irq_stat};
            end
            rmon_pkg::IRQ_MASK_ADDR: begin
                acc.rdata = {30'h0000_0000, q.irq_mask};
            end
            rmon_pkg::CAPS_ADDR: begin
                acc.rdata[rmon_pkg::CAP_QOS_BIT] = qos_on; // see R6
            end
            default: begin
                acc.rd_err = 1'b1;
            end
        endcase
        if (!qos_on || !acc.rd) begin
            if (acc.rd_err) begin
                acc.rdata = 32'h0000_0000;
            end
        end
    end

    // next state
    logic [rmon_pkg::IRQ_W-1:0] irq_set;
    logic [rmon_pkg::IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[rmon_pkg::IRQ_ERR_BIT] = err_evt;
        irq_set[rmon_pkg::IRQ_UNAV_BIT] = unav_evt;
    end
    assign irq_clr = wr_stat ? w1c_word[rmon_pkg::IRQ_W-1:0] : '0;

    always_comb begin
        d = q;
        d.evt_code = new_code; // see R1
        d.evt_tag = new_tag; // see R1
        if (wr_assoc_lo) begin
            d.assoc_tag = assoc_new[rmon_pkg::TAG_W-1:0]; // see R5
        end
        if (rd_ctr_lo) begin
            d.ctr_snap = ctr_live; // see R7
        end
        // a new event beats a clear in the same cycle
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
        if (wr_mask) begin
            d.irq_mask = w1c_word[rmon_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q.evt_code <= rmon_pkg::EVT_CODE_RST;
            q.evt_tag <= rmon_pkg::TAG_RST;
            q.assoc_tag <= rmon_pkg::TAG_RST;
            q.ctr_snap <= 64'h0000_0000_0000_0000;
            q.irq_stat <= rmon_pkg::IRQ_RST;
            q.irq_mask <= rmon_pkg::IRQ_RST;
        end else begin
            q <= d;
        end
    end

    assign mon_tag = q.evt_tag; // see R7
    assign mon_code = q.evt_code;
    assign assoc_tag = q.assoc_tag;
    assign irq = |(q.irq_stat & q.irq_mask);

    // checks
    evt_code_load_a: assert property ( // see R1
        @(posedge ref_clk) disable iff (!resetn)
        (wr_evt_lo && acc.wstrb[0]) |=> (mon_code == $past(acc.wdata[7:0]))
    ) else $error("event code not loaded from write");

    evt_tag_load_a: assert property ( // see R1
        @(posedge ref_clk) disable iff (!resetn)
        (wr_evt_hi && acc.wstrb[0] && acc.wstrb[1])
        |=> (mon_tag == $past(acc.wdata[9:0]))
    ) else $error("monitoring tag not loaded from write");

    ctr_data_read_a: assert property ( // see R2
        @(posedge ref_clk) disable iff (!resetn)
        rd_ctr_lo |=> (s_axi_rvalid && s_axi_rdata == $past(mon_data[31:0]))
    ) else $error("counter low word does not match monitored data");

    ctr_unavail_a: assert property ( // see R3
        @(posedge ref_clk) disable iff (!resetn)
        (rd_ctr_lo && !mon_avail) |=> q.ctr_snap[rmon_pkg::CTR_UNAVAIL_BIT]
    ) else $error("unavailable flag clear while data absent");

    sel_error_flag_a: assert property ( // see R4
        @(posedge ref_clk) disable iff (!resetn)
        (sel_wr && 32'(new_tag) >= NUM_TAGS) |=> (sel_err ##1 (sel_err || $past(sel_wr)))
    ) else $error("error flag not raised after unsupported tag");

    sel_error_ctr_a: assert property ( // see R4
        @(posedge ref_clk) disable iff (!resetn)
        (rd_ctr_lo && sel_err) |=> q.ctr_snap[rmon_pkg::CTR_ERR_BIT]
    ) else $error("counter error bit clear after bad selection");

    assoc_load_a: assert property ( // see R5
        @(posedge ref_clk) disable iff (!resetn)
        (wr_assoc_lo && acc.wstrb[0] && acc.wstrb[1])
        |=> (assoc_tag == $past(acc.wdata[9:0]))
    ) else $error("association tag not loaded from write");

    cap_absent_a: assert property ( // see R6
        @(posedge ref_clk) disable iff (!resetn)
        (acc.rd && !qos_on && acc.raddr == rmon_pkg::CTR_ADDR)
        |=> (s_axi_rvalid && s_axi_rresp == rmon_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    ) else $error("monitor register answered without capability");

    evt_reserved_a: assert property ( // see R7
        @(posedge ref_clk) disable iff (!resetn)
        (acc.rd && acc.raddr == rmon_pkg::EVTSEL_ADDR) |=> (s_axi_rdata[31:8] == 24'h0000_00)
    ) else $error("reserved event select bits read nonzero");

    irq_set_wins_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (unav_evt && wr_stat) |=> q.irq_stat[rmon_pkg::IRQ_UNAV_BIT]
    ) else $error("clear swallowed a same-cycle unavailable event");

    bresp_hold_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (s_axi_bvalid && !s_axi_bready) |=> ($stable(s_axi_bresp) && s_axi_bvalid)
    ) else $error("write response dropped before bready");

    wr_answer_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.wr |=> (s_axi_bvalid && s_axi_bresp == $past(acc.wr_err ? 2'h2 : 2'h0))
    ) else $error("write response missing one cycle after access");

    rd_answer_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        acc.rd |=> (s_axi_rvalid && s_axi_rresp == $past(acc.rd_err ? 2'h2 : 2'h0))
    ) else $error("read response missing one cycle after access");

    ctr_hi_snap_a: assert property ( // see R7
        @(posedge ref_clk) disable iff (!resetn)
        (acc.rd && qos_on && acc.raddr == (rmon_pkg::CTR_ADDR | rmon_pkg::HI_WIN))
        |=> (s_axi_rdata == $past(q.ctr_snap[63:32]))
    ) else $error("counter high word differs from snapshot");

endmodule

`default_nettype wire

/* tb/test_resource_monitor_regs.sv */
// self-checking bench for the resource monitor register bank
`default_nettype none

module test_resource_monitor_regs;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] HI = rmon_pkg::HI_WIN;
    localparam logic [15:0] SEL = rmon_pkg::EVTSEL_ADDR;
    localparam logic [15:0] CTR = rmon_pkg::CTR_ADDR;
    localparam logic [15:0] ASC = rmon_pkg::ASSOC_ADDR;
    localparam logic [61:0] DATA = 62'h1234_5678_9abc_def0;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [9:0] mon_tag;
    logic [7:0] mon_code;
    logic [61:0] mon_data = DATA;
    logic mon_avail = 1'b1;
    logic [9:0] assoc_tag;
    logic irq;
    int errors = 0;
    int total_checks = 0;

    rmon_regs rmon_regs_inst (.ref_clk(ref_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mon_tag(mon_tag),
        .mon_code(mon_code), .mon_data(mon_data), .mon_avail(mon_avail),
        .assoc_tag(assoc_tag), .irq(irq));

    always #25 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_bvalid === 1'b1) begin
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                s_axi_bready <= 1'b0;
                break;
            end
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_done;
        ar_done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_rvalid === 1'b1) begin
                chk("rdata", ed, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                s_axi_rready <= 1'b0;
                break;
            end
            if (!ar_done && s_axi_arready === 1'b1) begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask

    // low word snapshots the counter, high word returns the flags
    task automatic rd_ctr(input logic [1:0] flags);
        rd(CTR, DATA[31:0], rmon_pkg::RESP_OKAY);
        rd(CTR | HI, {flags, DATA[61:32]}, rmon_pkg::RESP_OKAY);
    endtask

    task automatic t_reset();
        rd(SEL, 32'h0000_0000, rmon_pkg::RESP_OKAY);
        rd(SEL | HI, 32'h0000_0000, rmon_pkg::RESP_OKAY);
        rd(ASC, 32'h0000_0000, rmon_pkg::RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_select();
        wr(SEL, 32'hffff_ff02, rmon_pkg::RESP_OKAY);
        wr(SEL | HI, 32'hffff_fc05, rmon_pkg::RESP_OKAY);
        chk("mon_code", 32'h02, {24'h0, mon_code});
        chk("mon_tag", 32'h05, {22'h0, mon_tag});
        rd(SEL, 32'h0000_0002, rmon_pkg::RESP_OKAY);
        rd(SEL | HI, 32'h0000_0005, rmon_pkg::RESP_OKAY);
        rd_ctr(2'b00);
    endtask

    task automatic t_unavail();
        mon_avail <= 1'b0;
        rd_ctr(2'b01);
        mon_avail <= 1'b1;
    endtask

    task automatic t_error();
        wr(SEL, 32'h0000_0004, rmon_pkg::RESP_OKAY);
        rd_ctr(2'b11);
        wr(SEL, 32'h0000_0003, rmon_pkg::RESP_OKAY);
        rd_ctr(2'b00);
        wr(SEL | HI, 32'h0000_0040, rmon_pkg::RESP_OKAY);
        rd_ctr(2'b11);
        wr(SEL | HI, 32'h0000_003f, rmon_pkg::RESP_OKAY);
        rd_ctr(2'b00);
    endtask

    task automatic t_assoc();
        wr(ASC, 32'hffff_ffff, rmon_pkg::RESP_OKAY);
        rd(ASC, 32'h0000_03ff, rmon_pkg::RESP_OKAY);
        chk("assoc_tag", 32'h3ff, {22'h0, assoc_tag});
        rd(ASC | HI, 32'h0000_0000, rmon_pkg::RESP_OKAY);
    endtask

    task automatic t_refuse();
        wr(CTR, 32'hffff_ffff, rmon_pkg::RESP_SLVERR);
        wr(CTR | HI, 32'hffff_ffff, rmon_pkg::RESP_SLVERR);
        rd_ctr(2'b00);
        rd(16'h0100, 32'h0000_0000, rmon_pkg::RESP_SLVERR);
        rd(rmon_pkg::CAPS_ADDR, 32'h0000_1000, rmon_pkg::RESP_OKAY);
    endtask

    task automatic t_irq();
        wr(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0003, rmon_pkg::RESP_OKAY);
        wr(rmon_pkg::IRQ_MASK_ADDR, 32'h0000_0001, rmon_pkg::RESP_OKAY);
        rd(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0000, rmon_pkg::RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
        wr(SEL, 32'h0000_00ff, rmon_pkg::RESP_OKAY);
        rd(rmon_pkg::IRQ_MASK_ADDR, 32'h0000_0001, rmon_pkg::RESP_OKAY);
        chk("irq", 32'h1, {31'h0, irq});
        mon_avail <= 1'b0;
        rd(CTR, DATA[31:0], rmon_pkg::RESP_OKAY);
        rd(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0003, rmon_pkg::RESP_OKAY);
        // a clear meeting a new unavailable event in one cycle loses to it
        fork
            wr(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0002, rmon_pkg::RESP_OKAY);
            begin
                @(posedge ref_clk);
                rd(CTR, DATA[31:0], rmon_pkg::RESP_OKAY);
            end
        join
        rd(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0003, rmon_pkg::RESP_OKAY);
        mon_avail <= 1'b1;
        wr(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0001, rmon_pkg::RESP_OKAY);
        rd(rmon_pkg::IRQ_STAT_ADDR, 32'h0000_0002, rmon_pkg::RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
        wr(SEL, 32'h0000_0001, rmon_pkg::RESP_OKAY);
        rd_ctr(2'b00);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_select();
        t_unavail();
        t_error();
        t_assoc();
        t_refuse();
        t_irq();
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
